// ==== rtl/sdco_cfg.svh ====
`ifndef SDCO_CFG_SVH
`define SDCO_CFG_SVH

// System clock rate, kHz
`define SDCO_SYS_CLK_KHZ 50000
// Selectable base frequencies, kHz
`define SDCO_BASE_1M0_KHZ 1000
`define SDCO_BASE_1M6_KHZ 1667
`define SDCO_BASE_3M3_KHZ 3333
`define SDCO_BASE_5M0_KHZ 5000
// Base period in system cycles, rounded to nearest
`define SDCO_CYC(f) ((`SDCO_SYS_CLK_KHZ + (f) / 2) / (f))
// Decade step between taps
`define SDCO_DECADE 10
`define SDCO_NUM_TAPS 5
`define SDCO_NUM_PINS 5
// Reset values
`define SDCO_OUT_RST 1'b0

`endif

// ==== rtl/sdco_pkg.sv ====
`default_nettype none

package sdco_pkg;

    typedef enum logic [1:0] {
        SDCO_BASE_1M0 = 2'b00,
        SDCO_BASE_1M6 = 2'b01,
        SDCO_BASE_3M3 = 2'b10,
        SDCO_BASE_5M0 = 2'b11
    } sdco_base_t;

    typedef enum logic [3:0] {
        SDCO_SRC_COUNT_INPUT_1 = 4'b0000,
        SDCO_SRC_COUNT_INPUT_2 = 4'b0001,
        SDCO_SRC_COUNT_INPUT_3 = 4'b0010,
        SDCO_SRC_COUNT_INPUT_4 = 4'b0011,
        SDCO_SRC_COUNT_INPUT_5 = 4'b0100,
        SDCO_SRC_GATING_1 = 4'b0101,
        SDCO_SRC_GATING_2 = 4'b0110,
        SDCO_SRC_GATING_3 = 4'b0111,
        SDCO_SRC_GATING_4 = 4'b1000,
        SDCO_SRC_GATING_5 = 4'b1001,
        SDCO_SRC_TAP_BASE = 4'b1010,
        SDCO_SRC_TAP_DIV10 = 4'b1011,
        SDCO_SRC_TAP_DIV100 = 4'b1100,
        SDCO_SRC_TAP_DIV1000 = 4'b1101,
        SDCO_SRC_TAP_DIV10000 = 4'b1110,
        SDCO_SRC_NONE = 4'b1111
    } sdco_src_t;

endpackage

`default_nettype wire

// ==== rtl/sdco_top.sv ====
// Overview of operation
// R1 - Base frequency selectable as 1.0000, 1.6667, 3.3333 or 5.0000 MHz.
// R2 - First internal tap equals the base frequency undivided.
// R3 - Taps two to five divide base by 10, 100, 1000, 10000.
// R4 - Source selector picks one of five taps or ten external pins.
// R5 - External source is any count input pin or any gating pin.
// R6 - Selected source divided by 1 to 16 drives the output pin.
// R7 - Outside circuitry keeps sources within 20 MHz input, 7 MHz gate.
// R8 - Divide by one passes source; else one period per N periods.
`include "sdco_cfg.svh"
`default_nettype none

module sdco_top
    import sdco_pkg::*;
#(
    parameter int NUM_TAPS = `SDCO_NUM_TAPS,
    parameter int NUM_PINS = `SDCO_NUM_PINS
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    // Configuration
    input wire sdco_base_t base_sel_i,
    input wire sdco_src_t src_sel_i,
    input wire logic [3:0] div_minus1_i,
    // External source pins
    input wire logic [NUM_PINS-1:0] count_input_terminals_i,
    input wire logic [NUM_PINS-1:0] gating_terminals_i,
    // Divided clock
    output logic divided_clock_output_pin_o
);

    localparam logic [5:0] CYC_1M0 = 6'(`SDCO_CYC(`SDCO_BASE_1M0_KHZ));
    localparam logic [5:0] CYC_1M6 = 6'(`SDCO_CYC(`SDCO_BASE_1M6_KHZ));
    localparam logic [5:0] CYC_3M3 = 6'(`SDCO_CYC(`SDCO_BASE_3M3_KHZ));
    localparam logic [5:0] CYC_5M0 = 6'(`SDCO_CYC(`SDCO_BASE_5M0_KHZ));
    localparam logic [3:0] DEC_LAST = 4'(`SDCO_DECADE - 1);
    localparam logic [3:0] DEC_HALF = 4'(`SDCO_DECADE / 2);

    logic [5:0] base_period;
    logic [5:0] presc;
    logic [NUM_TAPS-1:0] tap_tick;
    logic [NUM_TAPS-1:0] tap_lvl;
    logic [2*NUM_PINS-1:0] pin_meta;
    logic [2*NUM_PINS-1:0] pin_sync;
    logic sel_lvl;
    logic prev_lvl;
    logic src_edge;
    logic [3:0] half_cnt;

    // Base period in system cycles
    always_comb begin
        case (base_sel_i)  // see R1
            SDCO_BASE_1M0: base_period = CYC_1M0;
            SDCO_BASE_1M6: base_period = CYC_1M6;
            SDCO_BASE_3M3: base_period = CYC_3M3;
            SDCO_BASE_5M0: base_period = CYC_5M0;
            default: base_period = CYC_1M0;
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            presc <= 6'h00;
        end else if (presc >= base_period - 6'h01) begin
            presc <= 6'h00;  // see R1
        end else begin
            presc <= presc + 6'h01;
        end
    end

    // Base tap: high for the first half of each base period
    assign tap_tick[0] = (presc >= base_period - 6'h01);
    assign tap_lvl[0] = (presc < {1'b0, base_period[5:1]});  // see R2

    // Decade chain
    genvar k;
    generate
        for (k = 1; k < NUM_TAPS; k++) begin : g_decade
            logic [3:0] dec;
            always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
                if (!arst_n_i) begin
                    dec <= 4'h0;
                end else if (tap_tick[k-1]) begin
                    dec <= (dec >= DEC_LAST) ? 4'h0 : dec + 4'h1;  // see R3
                end
            end
            assign tap_tick[k] = tap_tick[k-1] && (dec >= DEC_LAST);  // see R3
            assign tap_lvl[k] = (dec < DEC_HALF);  // see R3
        end
    endgenerate

    // Pin synchronisers; gating pins sit above count inputs
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pin_meta <= '0;
            pin_sync <= '0;
        end else begin
            pin_meta <= {gating_terminals_i, count_input_terminals_i};
            pin_sync <= pin_meta;
        end
    end

    // Source selector
    always_comb begin
        sel_lvl = 1'b0;
        case (src_sel_i)  // see R4
            SDCO_SRC_COUNT_INPUT_1: sel_lvl = pin_sync[0];  // see R5
            SDCO_SRC_COUNT_INPUT_2: sel_lvl = pin_sync[1];
            SDCO_SRC_COUNT_INPUT_3: sel_lvl = pin_sync[2];
            SDCO_SRC_COUNT_INPUT_4: sel_lvl = pin_sync[3];
            SDCO_SRC_COUNT_INPUT_5: sel_lvl = pin_sync[4];
            SDCO_SRC_GATING_1: sel_lvl = pin_sync[5];  // see R5
            SDCO_SRC_GATING_2: sel_lvl = pin_sync[6];
            SDCO_SRC_GATING_3: sel_lvl = pin_sync[7];
            SDCO_SRC_GATING_4: sel_lvl = pin_sync[8];
            SDCO_SRC_GATING_5: sel_lvl = pin_sync[9];
            SDCO_SRC_TAP_BASE: sel_lvl = tap_lvl[0];
            SDCO_SRC_TAP_DIV10: sel_lvl = tap_lvl[1];
            SDCO_SRC_TAP_DIV100: sel_lvl = tap_lvl[2];
            SDCO_SRC_TAP_DIV1000: sel_lvl = tap_lvl[3];
            SDCO_SRC_TAP_DIV10000: sel_lvl = tap_lvl[4];
            default: sel_lvl = 1'b0;
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            prev_lvl <= 1'b0;
        end else begin
            prev_lvl <= sel_lvl;
        end
    end

    // Both edges count, so toggling every N edges gives N source periods
    assign src_edge = (sel_lvl != prev_lvl);  // see R8

    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            half_cnt <= 4'h0;
        end else if (src_edge) begin
            half_cnt <= (half_cnt >= div_minus1_i) ? 4'h0 : half_cnt + 4'h1;
        end
    end

    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            divided_clock_output_pin_o <= `SDCO_OUT_RST;
        end else if (src_edge && half_cnt >= div_minus1_i) begin
            divided_clock_output_pin_o <= ~divided_clock_output_pin_o;  // see R6
        end
    end

    // Helper: cycles between base ticks and base ticks per decade tick
    logic [6:0] gap;
    logic gap_ok;
    logic [3:0] sub_ticks;
    sdco_base_t prev_base;
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            gap <= 7'h00;
            gap_ok <= 1'b0;
            sub_ticks <= 4'h0;
            prev_base <= SDCO_BASE_1M0;
        end else begin
            prev_base <= base_sel_i;
            gap <= tap_tick[0] ? 7'h00 : gap + 7'h01;
            gap_ok <= (base_sel_i != prev_base) ? 1'b0
                    : (tap_tick[0] ? 1'b1 : gap_ok);
            if (tap_tick[1]) begin
                sub_ticks <= 4'h0;
            end else if (tap_tick[0]) begin
                sub_ticks <= sub_ticks + 4'h1;
            end
        end
    end

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!arst_n_i);

    base_period_ok_a: assert property ( // see R1
        tap_tick[0] && gap_ok && $stable(base_sel_i)
        |-> gap == {1'b0, base_period} - 7'h01)
        else $error("base period wrong");

    base_tap_rise_a: assert property ( // see R2
        $rose(tap_lvl[0]) && $stable(base_sel_i) |-> presc == 6'h00)
        else $error("base tap rises off period start");

    decade_ticks_a: assert property ( // see R3
        tap_tick[1] |-> sub_ticks == 4'h9 && tap_tick[0])
        else $error("decade tap not one in ten");

    tap_select_a: assert property ( // see R4
        src_sel_i == SDCO_SRC_TAP_DIV100 |-> sel_lvl == tap_lvl[2])
        else $error("tap select wrong");

    gate_select_a: assert property ( // see R5
        src_sel_i == SDCO_SRC_GATING_3 |-> sel_lvl == pin_sync[7])
        else $error("gating select wrong");

    div_toggle_a: assert property ( // see R6
        src_edge && half_cnt >= div_minus1_i
        |=> divided_clock_output_pin_o != $past(divided_clock_output_pin_o))
        else $error("output missed toggle");

    div_hold_a: assert property ( // see R8
        !(src_edge && half_cnt >= div_minus1_i)
        |=> $stable(divided_clock_output_pin_o))
        else $error("output toggled early");

    div_pass_a: assert property ( // see R8
        div_minus1_i == 4'h0 && src_edge
        |=> divided_clock_output_pin_o != $past(divided_clock_output_pin_o))
        else $error("divide by one not passing source");

    no_src_hold_a: assert property ( // see R4
        src_sel_i == SDCO_SRC_NONE && $past(src_sel_i) == SDCO_SRC_NONE
        |-> !src_edge)
        else $error("events with no source");

endmodule // sdco_top

`default_nettype wire

// ==== verification/sdco_ext_model.sv ====
`default_nettype none
module sdco_ext_model (
    // Clock and divided clock
    input wire logic sys_clk_i,
    input wire logic osc_i,
    // Source waves
    output logic wave_a_o,
    output logic wave_b_o,
    // Measured output
    output var int period_o,
    output var int rises_o
);
    timeunit 1ns;
    timeprecision 1ns;
    int ta = 0;
    int cnt = 0;
    logic prev = 1'b0;
    initial begin
        period_o = 0;
        rises_o = 0;
    end
    // Periods of 8 and 12 cycles keep under the gate-pin limit
    always @(negedge sys_clk_i) begin
        ta = (ta + 1) % 24;
        wave_a_o = (ta % 8) < 4;
        wave_b_o = (ta % 12) < 6;
    end
    always @(posedge sys_clk_i) begin
        cnt = cnt + 1;
        if (osc_i && !prev) begin
            period_o = cnt;
            rises_o = rises_o + 1;
            cnt = 0;
        end
        prev = osc_i;
    end
endmodule // sdco_ext_model
`default_nettype wire

// ==== verification/selectable_divided_clock_out_tb.sv ====
`default_nettype none
module selectable_divided_clock_out_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import sdco_pkg::*;
    typedef struct {
        sdco_base_t b;
        sdco_src_t s;
        logic [3:0] d;
        int p;
    } sdco_row_t;
    logic sys_clk, arst_n, osc, wave_a, wave_b;
    sdco_base_t base_sel;
    sdco_src_t src_sel;
    logic [3:0] div_m1;
    logic [4:0] cmask, gmask, cnt_pins, gate_pins;
    int period, rises, mismatches = 0, compares = 0;
    sdco_row_t rows [7] = '{
        '{SDCO_BASE_1M0, SDCO_SRC_TAP_BASE, 4'h0, 50},
        '{SDCO_BASE_1M6, SDCO_SRC_TAP_BASE, 4'h0, 30},
        '{SDCO_BASE_3M3, SDCO_SRC_TAP_BASE, 4'h1, 30},
        '{SDCO_BASE_5M0, SDCO_SRC_TAP_BASE, 4'hF, 160},
        '{SDCO_BASE_1M0, SDCO_SRC_TAP_DIV10, 4'h0, 500},
        '{SDCO_BASE_5M0, SDCO_SRC_TAP_DIV100, 4'h0, 1000},
        '{SDCO_BASE_5M0, SDCO_SRC_TAP_DIV1000, 4'h0, 10000}};
    // Only the selected pin carries wave a, all others wave b
    assign cmask = (src_sel < 5) ? 5'(1 << src_sel) : 5'h00;
    assign gmask = (src_sel >= 5 && src_sel < 10) ?
        5'(1 << (src_sel - 5)) : 5'h00;
    assign cnt_pins = ({5{wave_a}} & cmask) | ({5{wave_b}} & ~cmask);
    assign gate_pins = ({5{wave_a}} & gmask) | ({5{wave_b}} & ~gmask);
    sdco_top DUT (.sys_clk_i(sys_clk), .arst_n_i(arst_n),
        .base_sel_i(base_sel), .src_sel_i(src_sel), .div_minus1_i(div_m1),
        .count_input_terminals_i(cnt_pins), .gating_terminals_i(gate_pins),
        .divided_clock_output_pin_o(osc));
    sdco_ext_model ext (.sys_clk_i(sys_clk), .osc_i(osc),
        .wave_a_o(wave_a), .wave_b_o(wave_b),
        .period_o(period), .rises_o(rises));
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Apply a setting, then take the period between the 2nd and 3rd rise
    task automatic run(input sdco_base_t b, input sdco_src_t s,
                       input logic [3:0] d, output int p);
        int r0;
        @(negedge sys_clk);
        base_sel = b;
        src_sel = s;
        div_m1 = d;
        r0 = rises;
        for (int i = 0; i < 40000 && rises < r0 + 3; i++) begin
            @(negedge sys_clk);
        end
        check(rises - r0, 3);
        p = period;
    endtask
    task automatic wrap_up();
        $display("mismatches=%0d compares=%0d", mismatches, compares);
        if (mismatches == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        #2000000;
        mismatches++;
        wrap_up();
    end
    initial begin
        int p, r0;
        logic held;
        base_sel = SDCO_BASE_1M0;
        src_sel = SDCO_SRC_NONE;
        div_m1 = 4'h0;
        arst_n = 1'b0;
        repeat (20) @(negedge sys_clk);
        arst_n = 1'b1;
        foreach (rows[i]) begin
            run(rows[i].b, rows[i].s, rows[i].d, p);
            check(p, rows[i].p);
        end
        for (int k = 0; k < 10; k++) begin
            run(SDCO_BASE_5M0, sdco_src_t'(k), 4'(k), p);
            check(p, 8 * (k + 1));
        end
        // No source selected: output must hold its level
        src_sel = SDCO_SRC_NONE;
        repeat (10) @(negedge sys_clk);
        r0 = rises;
        held = osc;
        repeat (300) @(negedge sys_clk);
        check(rises, r0);
        check(osc, held);
        // Reset in mid-run drives the output low at once
        run(SDCO_BASE_5M0, SDCO_SRC_TAP_BASE, 4'h0, p);
        arst_n = 1'b0;
        #1 check(osc, 1'b0);
        repeat (3) @(negedge sys_clk);
        check(osc, 1'b0);
        arst_n = 1'b1;
        #1 check(osc, 1'b0);
        @(negedge sys_clk);
        check(osc, 1'b1);
        wrap_up();
    end
endmodule // selectable_divided_clock_out_tb
`default_nettype wire
